// ===== hbp_pkg.sv
package hbp_pkg;
    // ==========================================================
    // Widths and window layout
    localparam int unsigned ADDR_W       = 17;
    localparam int unsigned DATA_W       = 16;
    localparam int unsigned WINDOW_BYTES = 131072;
    localparam int unsigned BUF_BYTES    = 81920;
    localparam int unsigned BUF_WORDS    = BUF_BYTES / 2;
    localparam logic [16:0] REG_BASE     = 17'h1ffe0;
    // Register indices inside the 32-byte register block
    localparam logic [4:0]  REVISION_CODE_IDX = 5'h00;
    // Revision value is arbitrary
    localparam logic [7:0]  REVISION_VALUE    = 8'h5a;
    // Strap pattern selecting the general 16-bit mode
    localparam logic [2:0]  MODE_GENERIC16    = 3'b111;
    localparam logic        CYCLE_BEGIN_GEN   = 1'b0;
    // Device turnaround: countdown start; ST_ARB lasts this many cycles plus one
    localparam int unsigned ARB_CYCLES        = 2;
    localparam logic [1:0]  ARB_CNT_INIT      = 2'(ARB_CYCLES);
    // Host command/status register map (Avalon word addresses)
    localparam logic [2:0]  CMD_ADDR_OFS  = 3'h0;
    localparam logic [2:0]  CMD_WDATA_OFS = 3'h1;
    localparam logic [2:0]  CMD_CTRL_OFS  = 3'h2;
    localparam logic [2:0]  CMD_STAT_OFS  = 3'h3;
    localparam logic [2:0]  CMD_RDATA_OFS = 3'h4;
    // Control field positions
    localparam int unsigned CTRL_GO_BIT   = 0;
    localparam int unsigned CTRL_WR_BIT   = 1;
    localparam int unsigned CTRL_LO_BIT   = 2;
    localparam int unsigned CTRL_HI_BIT   = 3;
endpackage

// ===== hbp_if.sv
`timescale 1ns/10ps
interface hbp_if;
    import hbp_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] host_data;
    logic [DATA_W-1:0] dev_data;
    logic              dev_data_oe_n;
    logic              dev_select_n;
    logic              low_byte_write_strobe_n;
    logic              high_byte_write_strobe_n;
    logic              low_byte_read_strobe_n;
    logic              high_byte_read_strobe_n;
    logic              hold_off_n;
    logic              transfer_acknowledge_n;

    // Glue: inverter enabled by select, acknowledge while not held off
    assign transfer_acknowledge_n = dev_select_n ? 1'b1 : ~hold_off_n;

    modport device (
        input  addr, host_data, dev_select_n, low_byte_write_strobe_n,
               high_byte_write_strobe_n, low_byte_read_strobe_n,
               high_byte_read_strobe_n,
        output dev_data, dev_data_oe_n, hold_off_n
    );
    modport host (
        input  dev_data, dev_data_oe_n, transfer_acknowledge_n,
        output addr, host_data, dev_select_n, low_byte_write_strobe_n,
               high_byte_write_strobe_n, low_byte_read_strobe_n,
               high_byte_read_strobe_n
    );
endinterface

// ===== hbp_device.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
module hbp_device
    import hbp_pkg::*;
(
    // Clock and reset (host interface clock)
    input  wire logic host_interface_clock,
    input  wire logic nrst,
    // Configuration straps
    input  wire logic byte_order_strap,
    input  wire logic bus_mode_strap_2,
    input  wire logic bus_mode_strap_1,
    input  wire logic bus_mode_strap_0,
    input  wire logic cycle_begin_strap_n,
    // Status
    output logic      port_enabled,
    output logic      big_endian,
    // Bus
    hbp_if.device     bus
);
    // ==========================================================
    // Types and state
    // Access sequencer: idle, arbitration hold-off, completion
    typedef enum logic [1:0] {ST_IDLE, ST_ARB, ST_DONE} dstate_e;

    // Whole port state in one record
    typedef struct packed {
        dstate_e           st;          // Access sequencer
        logic [1:0]        cnt;         // Arbitration cycles left
        logic              strap_taken; // Straps already latched
        logic              big;         // Big-endian byte order
        logic              en;          // Port enabled by straps
        logic [DATA_W-1:0] rdata;       // Read word toward host
        logic              oe_n;        // Read data driven when low
        logic              hold_n;      // Hold-off toward host
    } dev_s;

    dev_s              s_q;
    dev_s              s_d;

    // Display buffer storage, one entry per 16-bit word
    logic [DATA_W-1:0] mem [BUF_WORDS];

    // Decoded access attributes
    logic [15:0]       widx;
    logic              in_buf;
    logic              in_reg;
    logic              wr;
    logic              rd;
    logic              lo;
    logic              hi;
    logic              mem_we;
    logic [DATA_W-1:0] wval;

    // ==========================================================
    // Functions
    // Swap bytes for big-endian order
    function automatic logic [15:0] order(input logic [15:0] v, input logic b);
        return b ? {v[7:0], v[15:8]} : v;
    endfunction

    // Pick a lane strobe; big-endian crosses the lanes
    function automatic logic lane(input logic same_n, input logic cross_n, input logic b);
        return b ? ~cross_n : ~same_n;
    endfunction

    // Register block read value for a word address
    function automatic logic [15:0] reg_word(input logic [ADDR_W-1:0] a);
        logic [15:0] v;
        v = '0;
        // Only the revision index is decoded; others read zero
        if (a[4:1] == REVISION_CODE_IDX[4:1]) begin
            v = {REVISION_VALUE, REVISION_VALUE};
        end
        return v;
    endfunction

    // ==========================================================
    // Decode
    // buffer and register window
    assign in_buf = (32'(bus.addr) < BUF_BYTES);
    // Register block covers the top of the window
    assign in_reg = (bus.addr >= REG_BASE);

    // Word index into the buffer
    assign widx = 16'(bus.addr[ADDR_W-1:1]);

    assign wr = ~bus.low_byte_write_strobe_n | ~bus.high_byte_write_strobe_n;
    assign rd = ~bus.low_byte_read_strobe_n | ~bus.high_byte_read_strobe_n;

    assign lo   = lane(bus.low_byte_write_strobe_n, bus.high_byte_write_strobe_n, s_q.big);
    assign hi   = lane(bus.high_byte_write_strobe_n, bus.low_byte_write_strobe_n, s_q.big);
    assign wval = order(bus.host_data, s_q.big);

    // Buffer write on the last arbitration cycle
    assign mem_we = (s_q.st == ST_ARB) && (s_q.cnt == 2'd0) && wr && in_buf;

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        if (!s_q.strap_taken) begin
            s_d.strap_taken = 1'b1;
            s_d.big         = byte_order_strap;
            s_d.en = ({bus_mode_strap_2, bus_mode_strap_1, bus_mode_strap_0}
                      == MODE_GENERIC16) && (cycle_begin_strap_n == CYCLE_BEGIN_GEN);
        end
        unique case (s_q.st)
            // Wait for a selected strobe
            ST_IDLE: begin
                // Bus released while idle
                s_d.oe_n   = 1'b1;
                s_d.hold_n = 1'b1;
                if (s_q.en && !bus.dev_select_n && (wr || rd)) begin
                    s_d.hold_n = 1'b0;
                    s_d.cnt    = ARB_CNT_INIT;
                    s_d.st     = ST_ARB;
                end
            end
            // Count down the refresh arbitration slot
            ST_ARB: begin
                s_d.hold_n = 1'b0;
                if (s_q.cnt != 2'd0) begin
                    s_d.cnt = s_q.cnt - 2'd1;
                end else begin
                    // Read word ready together with the release
                    if (rd) begin
                        if (in_buf) begin
                            s_d.rdata = order(mem[widx], s_q.big);
                        end else if (in_reg) begin
                            s_d.rdata = reg_word(bus.addr);
                        end else begin
                            s_d.rdata = '0;
                        end
                        s_d.oe_n = 1'b0;
                    end
                    // Buffer write lands on this edge; release the host
                    s_d.hold_n = 1'b1;
                    s_d.st     = ST_DONE;
                end
            end
            // Keep read data until the host lets go
            ST_DONE: begin
                // Select dropped or strobes gone
                if (bus.dev_select_n || !(wr || rd)) begin
                    s_d.oe_n = 1'b1;
                    s_d.st   = ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers
    // clocked by host interface clock
    always_ff @(posedge host_interface_clock or negedge nrst) begin
        if (!nrst) begin
            // Idle, straps not yet taken, bus released
            s_q <= '{st: ST_IDLE, cnt: 2'd0, strap_taken: 1'b0, big: 1'b0,
                     en: 1'b0, rdata: '0, oe_n: 1'b1, hold_n: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Display buffer
    // only strobed lanes written
    always_ff @(posedge host_interface_clock) begin
        if (mem_we && lo) begin
            mem[widx][7:0] <= wval[7:0];
        end
        if (mem_we && hi) begin
            mem[widx][15:8] <= wval[15:8];
        end
    end

    // ==========================================================
    // Outputs
    // Bus side, all from flip-flops
    assign bus.dev_data      = s_q.rdata;
    assign bus.dev_data_oe_n = s_q.oe_n;
    assign bus.hold_off_n    = s_q.hold_n;

    // Strap results for status
    assign port_enabled = s_q.en;
    assign big_endian   = s_q.big;
endmodule

// ===== hbp_host.sv
`timescale 1ns/10ps
module hbp_host
    import hbp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Avalon-MM slave
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Bus
    hbp_if.host              bus
);
    typedef enum logic [1:0] {H_IDLE, H_ADDR, H_SEL, H_END} hstate_e;

    typedef struct packed {
        hstate_e           st;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic              wr;
        logic              lo;
        logic              hi;
        logic              busy;
        logic              sel_n;
        logic              ack_q;
        logic [31:0]       rd_q;
        logic              rvalid;
    } host_s;

    host_s s_q, s_d;

    // Read data mux
    function automatic logic [31:0] rd_mux(input host_s s, input logic [2:0] a);
        unique case (a)
            CMD_ADDR_OFS:  return 32'(s.addr);
            CMD_WDATA_OFS: return 32'(s.wdata);
            CMD_STAT_OFS:  return {31'h0, s.busy};
            CMD_RDATA_OFS: return 32'(s.rdata);
            default:       return 32'h0;
        endcase
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        if (avs_read && !s_q.rvalid) begin
            s_d.rd_q   = rd_mux(s_q, avs_address);
            s_d.rvalid = 1'b1;
        end
        if (avs_write && !s_q.busy) begin
            if (avs_address == CMD_ADDR_OFS)
                s_d.addr = avs_writedata[ADDR_W-1:0];
            if (avs_address == CMD_WDATA_OFS)
                s_d.wdata = avs_writedata[DATA_W-1:0];
            if (avs_address == CMD_CTRL_OFS && avs_writedata[CTRL_GO_BIT]) begin
                s_d.wr   = avs_writedata[CTRL_WR_BIT];
                s_d.lo   = avs_writedata[CTRL_LO_BIT];
                s_d.hi   = avs_writedata[CTRL_HI_BIT];
                s_d.busy = 1'b1;
                s_d.st   = H_ADDR;
            end
        end
        unique case (s_q.st)
            H_IDLE: s_d.sel_n = 1'b1;
            H_ADDR: begin
                s_d.sel_n = 1'b0;
                s_d.ack_q = 1'b0;
                s_d.st    = H_SEL;
            end
            H_SEL: begin
                if (!bus.transfer_acknowledge_n && s_q.ack_q) begin
                    if (!s_q.wr)
                        s_d.rdata = bus.dev_data;
                    s_d.sel_n = 1'b1;
                    s_d.st    = H_END;
                end
                s_d.ack_q = 1'b1;
            end
            H_END: begin
                s_d.busy = 1'b0;
                s_d.st   = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            s_q <= '{st: H_IDLE, sel_n: 1'b1, default: '0};
        else
            s_q <= s_d;
    end

    // ==========================================================
    // Outputs
    assign avs_readdata    = s_q.rd_q;
    assign avs_waitrequest = (avs_read && !s_q.rvalid) || (avs_write && s_q.busy);
    assign bus.addr         = s_q.addr;
    assign bus.host_data    = s_q.wdata;
    assign bus.dev_select_n = s_q.sel_n;
    assign bus.low_byte_write_strobe_n  = ~(s_q.busy && s_q.wr && s_q.lo && !s_q.sel_n);
    assign bus.high_byte_write_strobe_n = ~(s_q.busy && s_q.wr && s_q.hi && !s_q.sel_n);
    assign bus.low_byte_read_strobe_n   = ~(s_q.busy && !s_q.wr && s_q.lo && !s_q.sel_n);
    assign bus.high_byte_read_strobe_n  = ~(s_q.busy && !s_q.wr && s_q.hi && !s_q.sel_n);
endmodule

// ===== hbp_checker.sv
`timescale 1ns/10ps
module hbp_checker
    import hbp_pkg::*;
(
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              nrst,
    // Bus signals
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              dev_data_oe_n,
    input wire logic              dev_select_n,
    input wire logic              low_byte_write_strobe_n,
    input wire logic              high_byte_write_strobe_n,
    input wire logic              low_byte_read_strobe_n,
    input wire logic              high_byte_read_strobe_n,
    input wire logic              hold_off_n,
    input wire logic              transfer_acknowledge_n
);
    // ==========================================================
    // Common clocking
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Any write or read strobe low
    wire logic wr_any = !low_byte_write_strobe_n || !high_byte_write_strobe_n;
    wire logic rd_any = !low_byte_read_strobe_n || !high_byte_read_strobe_n;

    // ==========================================================
    // Assertions
    a_hold_on_select: assert property ($fell(dev_select_n) |=> !hold_off_n)
        else $error("hold-off not raised after select");
    a_hold_three_low: assert property (
        $fell(hold_off_n) |-> !hold_off_n [*3] ##1 hold_off_n)
        else $error("hold-off length wrong");
    a_read_data_out: assert property ($rose(hold_off_n) && rd_any |-> !dev_data_oe_n)
        else $error("read data not driven at release");
    a_write_no_drive: assert property ($rose(hold_off_n) && wr_any |-> dev_data_oe_n)
        else $error("device drives data in a write");
    a_ack_ends_cycle: assert property (
        !transfer_acknowledge_n && $past(!hold_off_n) |=> dev_select_n)
        else $error("select held past acknowledge");
    a_no_early_end: assert property (
        $rose(dev_select_n) |-> $past(!hold_off_n, 2))
        else $error("cycle ended before hold-off");
    a_single_cycle: assert property ($rose(dev_select_n) |-> dev_select_n [*2])
        else $error("select reasserted back to back");
    a_addr_held: assert property (
        !dev_select_n && $past(!dev_select_n) |-> $stable(addr))
        else $error("address moved under select");
    a_strobe_kinds: assert property (!(wr_any && rd_any))
        else $error("read and write strobes together");

    // Main scenarios
    c_read: cover property ($rose(hold_off_n) && rd_any);
    c_write: cover property ($rose(hold_off_n) && wr_any);
    c_byte_write: cover property ($rose(hold_off_n) && !low_byte_write_strobe_n
        && high_byte_write_strobe_n);
endmodule

// ===== generic_host_bus_port_tb.sv
`timescale 1ns/10ps
module generic_host_bus_port_tb
    import hbp_pkg::*;
;
    logic        clk_sys, nrst, avs_read, avs_write, avs_waitrequest;
    logic        byte_order_strap, bus_mode_strap_2, bus_mode_strap_1, bus_mode_strap_0;
    logic        cycle_begin_strap_n, port_enabled, big_endian;
    logic [2:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    int          fail_count, checks;

    // ==========================================================
    // Both ends on one shared clock
    hbp_if hbp_if_i ();
    hbp_device hbp_device_i (.host_interface_clock(clk_sys), .nrst(nrst),
        .byte_order_strap(byte_order_strap), .bus_mode_strap_2(bus_mode_strap_2),
        .bus_mode_strap_1(bus_mode_strap_1), .bus_mode_strap_0(bus_mode_strap_0),
        .cycle_begin_strap_n(cycle_begin_strap_n), .port_enabled(port_enabled),
        .big_endian(big_endian), .bus(hbp_if_i));
    hbp_host hbp_host_i (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus(hbp_if_i));
    hbp_checker hbp_checker_i (.clk_sys(clk_sys), .nrst(nrst), .addr(hbp_if_i.addr),
        .dev_data_oe_n(hbp_if_i.dev_data_oe_n), .dev_select_n(hbp_if_i.dev_select_n),
        .low_byte_write_strobe_n(hbp_if_i.low_byte_write_strobe_n),
        .high_byte_write_strobe_n(hbp_if_i.high_byte_write_strobe_n),
        .low_byte_read_strobe_n(hbp_if_i.low_byte_read_strobe_n),
        .high_byte_read_strobe_n(hbp_if_i.high_byte_read_strobe_n),
        .hold_off_n(hbp_if_i.hold_off_n),
        .transfer_acknowledge_n(hbp_if_i.transfer_acknowledge_n));

    // 100 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Avalon cycle held until the edge that sees waitrequest low
    task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys);
    endtask

    // One device access; lanes {hi, lo}; read word ends in rd
    task automatic acc(input logic wr, input logic [1:0] ln, input logic [16:0] a,
                       input logic [15:0] d);
        av(1'b1, CMD_ADDR_OFS, 32'(a));
        av(1'b1, CMD_WDATA_OFS, 32'(d));
        av(1'b1, CMD_CTRL_OFS, {28'h0, ln, wr, 1'b1});
        do begin
            av(1'b0, CMD_STAT_OFS, 32'h0);
        end while (rd[0] !== 1'b0);
        av(1'b0, CMD_RDATA_OFS, 32'h0);
    endtask

    // Straps {order, mode 2..0, begin}, reset for 12 cycles
    task automatic rst(input logic [4:0] st);
        {byte_order_strap, bus_mode_strap_2, bus_mode_strap_1, bus_mode_strap_0,
            cycle_begin_strap_n} <= st;
        nrst <= 1'b0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_straps();
        logic [4:0] st [4] = '{5'h1f, 5'h0c, 5'h1e, 5'h0e};
        foreach (st[i]) begin
            rst(st[i]);
            chk("port_enabled", 32'(st[i][3:0] == 4'he), 32'(port_enabled));
            chk("big_endian", 32'(st[i][4]), 32'(big_endian));
        end
        bus_mode_strap_0 <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("port_enabled held", 32'h1, 32'(port_enabled));
        bus_mode_strap_0 <= 1'b1;
        @(posedge clk_sys);
    endtask

    task automatic t_regs();
        acc(1'b0, 2'h3, REG_BASE, 16'h0);
        chk("revision word", 32'({REVISION_VALUE, REVISION_VALUE}), 32'(rd[15:0]));
        acc(1'b0, 2'h1, REG_BASE, 16'h0);
        chk("revision byte", 32'(REVISION_VALUE), 32'(rd[7:0]));
        acc(1'b1, 2'h3, REG_BASE, 16'h0);
        acc(1'b0, 2'h3, REG_BASE, 16'h0);
        chk("revision kept", 32'({REVISION_VALUE, REVISION_VALUE}), 32'(rd[15:0]));
        acc(1'b0, 2'h3, REG_BASE + 17'h2, 16'hffff);
        chk("empty index", 32'h0, 32'(rd[15:0]));
        av(1'b0, 3'h5, 32'h0);
        chk("unmapped avalon", 32'h0, rd);
    endtask

    task automatic t_buf();
        acc(1'b1, 2'h3, 17'h0, 16'h1234);
        acc(1'b1, 2'h3, 17'h13ffe, 16'hbeef);
        acc(1'b0, 2'h3, 17'h0, 16'h0);
        chk("word 0", 32'h1234, 32'(rd[15:0]));
        acc(1'b0, 2'h3, 17'h13ffe, 16'h0);
        chk("last word", 32'hbeef, 32'(rd[15:0]));
        acc(1'b1, 2'h1, 17'h0, 16'h00ab);
        acc(1'b0, 2'h3, 17'h0, 16'h0);
        chk("low lane", 32'h12ab, 32'(rd[15:0]));
        acc(1'b1, 2'h2, 17'h0, 16'hcd00);
        acc(1'b0, 2'h3, 17'h0, 16'h0);
        chk("high lane", 32'hcdab, 32'(rd[15:0]));
    endtask

    // Buffer kept over reset, seen again in big-endian order
    task automatic t_order();
        rst(5'h1e);
        chk("big_endian set", 32'h1, 32'(big_endian));
        acc(1'b0, 2'h3, 17'h0, 16'h0);
        chk("swapped word", 32'habcd, 32'(rd[15:0]));
        acc(1'b1, 2'h1, 17'h0, 16'h0012);
        acc(1'b0, 2'h3, 17'h0, 16'h0);
        chk("swapped low lane", 32'hab12, 32'(rd[15:0]));
    endtask

    task automatic summarize();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {byte_order_strap, bus_mode_strap_2, bus_mode_strap_1} = 3'h3;
        {bus_mode_strap_0, cycle_begin_strap_n} = 2'h2;
        fail_count = 0;
        checks = 0;
        t_straps();
        t_regs();
        t_buf();
        t_order();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        summarize();
    end
endmodule
